// >>> rtl/pmic_control_pin_logic.sv
// Control-pin logic: rail enables, sleep control, interrupt and GPOs.
// How it works
// - Enable pin high turns its rails on.
// - Combined pin low puts its group asleep.
// - Sleeping rails use their own sleep setting.
// - Interrupt line only pulled low or released.
// - Each GPO selects open-drain or push-pull.
// - Each GPO can show selected rails' power-good.
// - Each GPO can follow a software bit.
`timescale 1ns/1ps
`default_nettype none
module pmic_control_pin_logic
  import pmic_pin_pkg::*;
(
  input wire logic clk, // System clock, 100 MHz.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; all state holds while low.
  input wire logic [pmic_pin_pkg::ADDR_W-1:0] reg_addr, // Register address.
  input wire logic [pmic_pin_pkg::DATA_W-1:0] reg_wdata, // Write data.
  input wire logic reg_we, // Write strobe.
  input wire logic reg_re, // Read strobe.
  output logic [pmic_pin_pkg::DATA_W-1:0] reg_rdata, // Read data, next cycle.
  input wire logic rail_group_enable_in_a, // Active-high group enable pin.
  input wire logic rail_enable_or_sleep_in, // Enable or sleep pin.
  input wire logic [pmic_pin_pkg::NUM_RAILS-1:0] rail_pg, // Rail power-good.
  output logic [pmic_pin_pkg::NUM_RAILS-1:0] rail_enable, // Rail on.
  output logic [pmic_pin_pkg::NUM_RAILS-1:0] rail_sleep, // Rail in sleep.
  output logic [pmic_pin_pkg::NUM_RAILS*8-1:0] rail_vsel, // Voltage codes.
  output logic interrupt_out_n_o, // Interrupt pin output level.
  output logic interrupt_out_n_oe_n, // Interrupt pin enable, low drives.
  output logic general_out_a_o, // GPO a level.
  output logic general_out_a_oe_n, // GPO a enable, low drives.
  output logic general_out_b_o, // GPO b level.
  output logic general_out_b_oe_n, // GPO b enable, low drives.
  output logic general_out_c_o, // GPO c level.
  output logic general_out_c_oe_n // GPO c enable, low drives.
);
  // Configuration registers.
  logic [7:0] map_a_reg; // Rails switched by the group enable pin.
  logic [7:0] map_b_reg; // Rails switched by the combined pin.
  logic [7:0] pin_cfg_reg; // Combined pin mode.
  logic [7:0] sleep_map_reg; // Rails sent to sleep by the combined pin.
  logic [7:0] sw_en_reg; // Rails forced on by software.
  logic [7:0] gpo_cfg_reg; // Drive type and source per GPO.
  logic [7:0] gpo_out_reg; // Software levels for GPOs.
  logic [7:0] pg_mask_reg [NUM_GPO]; // Power-good rail sets per GPO.
  logic [7:0] irq_status_reg; // Sticky event flags.
  logic [7:0] irq_mask_reg; // Event enables.
  logic [7:0] vsel_norm_reg [NUM_RAILS]; // Normal voltage codes.
  logic [7:0] vsel_sleep_reg [NUM_RAILS]; // Sleep voltage codes.

  // Previous pin and power-good samples for event detection.
  logic pin_a_reg; // Last group enable pin level.
  logic pin_b_reg; // Last combined pin level.
  logic [NUM_RAILS-1:0] pg_reg; // Last power-good vector.

  // Derived signals.
  logic sleep_mode; // Combined pin acts as sleep control.
  logic [NUM_RAILS-1:0] rail_enable_next; // Next rail enable vector.
  logic [NUM_RAILS-1:0] rail_sleep_next; // Next rail sleep vector.
  logic [NUM_EVENTS-1:0] events; // Event pulses this cycle.
  logic [DATA_W-1:0] ev_set; // Event pulses at the status width.
  logic wr_irq_status; // Software clears status bits.
  logic [NUM_GPO-1:0] gpo_pin; // GPO levels.
  logic [NUM_GPO-1:0] gpo_oe_n; // GPO enables.

  // Select a rail set when a pin is active.
  function automatic logic [NUM_RAILS-1:0] gate_map(input logic [7:0] map,
                                                    input logic active);
    gate_map = active ? map[NUM_RAILS-1:0] : '0;
  endfunction : gate_map

  // Decode a write to one address.
  function automatic logic wr_hit(input logic we,
                                  input logic [ADDR_W-1:0] addr,
                                  input logic [ADDR_W-1:0] target);
    wr_hit = we && (addr == target);
  endfunction : wr_hit

  assign sleep_mode = pin_cfg_reg[PIN_CFG_SLEEP_BIT];
  assign wr_irq_status = wr_hit(reg_we, reg_addr, ADDR_IRQ_STATUS);
  assign ev_set = DATA_W'(events);

  // Rails follow their enable pins; the combined pin enables only
  // while it is not in sleep mode.
  always_comb
  begin
    rail_enable_next = gate_map(map_a_reg, rail_group_enable_in_a)
      | gate_map(map_b_reg, rail_enable_or_sleep_in && !sleep_mode)
      | sw_en_reg[NUM_RAILS-1:0];
    // A low combined pin in sleep mode puts its group to sleep.
    rail_sleep_next = gate_map(sleep_map_reg,
      sleep_mode && !rail_enable_or_sleep_in);
  end

  // Events: pin edges and loss of power-good on a running rail.
  always_comb
  begin
    events = '0;
    events[EV_A_RISE] = rail_group_enable_in_a && !pin_a_reg;
    events[EV_A_FALL] = !rail_group_enable_in_a && pin_a_reg;
    events[EV_B_RISE] = rail_enable_or_sleep_in && !pin_b_reg;
    events[EV_B_FALL] = !rail_enable_or_sleep_in && pin_b_reg;
    events[EV_PG_FAULT] = |(pg_reg & ~rail_pg & rail_enable);
  end

  // Register the rail controls and their voltage codes.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rail_enable <= '0;
      rail_sleep <= '0;
      rail_vsel <= '0;
    end
    else if (ce)
    begin
      rail_enable <= rail_enable_next;
      rail_sleep <= rail_sleep_next;
      for (int i = 0; i < NUM_RAILS; i++)
      begin
        // Sleeping rails regulate to their sleep code.
        rail_vsel[i*8 +: 8] <= rail_sleep_next[i] ? vsel_sleep_reg[i]
          : vsel_norm_reg[i];
      end
    end
  end

  // Keep last samples for edge detection.
  // Reset loads the live pin levels, so no false edge follows reset.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_a_reg <= rail_group_enable_in_a;
      pin_b_reg <= rail_enable_or_sleep_in;
      pg_reg <= '0;
    end
    else if (ce)
    begin
      pin_a_reg <= rail_group_enable_in_a;
      pin_b_reg <= rail_enable_or_sleep_in;
      pg_reg <= rail_pg;
    end
  end

  // Configuration register writes.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      map_a_reg <= RST_MAP;
      map_b_reg <= RST_MAP;
      pin_cfg_reg <= RST_PIN_CFG;
      sleep_map_reg <= RST_MAP;
      sw_en_reg <= RST_ZERO;
      gpo_cfg_reg <= RST_GPO_CFG;
      gpo_out_reg <= RST_ZERO;
      irq_mask_reg <= RST_ZERO;
      for (int i = 0; i < NUM_GPO; i++)
      begin
        pg_mask_reg[i] <= RST_ZERO;
      end
      for (int i = 0; i < NUM_RAILS; i++)
      begin
        vsel_norm_reg[i] <= RST_VSEL_NORM;
        vsel_sleep_reg[i] <= RST_VSEL_SLEEP;
      end
    end
    else if (ce && reg_we)
    begin
      case (reg_addr)
        ADDR_MAP_A: map_a_reg <= reg_wdata;
        ADDR_MAP_B: map_b_reg <= reg_wdata;
        ADDR_PIN_CFG: pin_cfg_reg <= reg_wdata;
        ADDR_SLEEP_MAP: sleep_map_reg <= reg_wdata;
        ADDR_SW_EN: sw_en_reg <= reg_wdata;
        ADDR_GPO_CFG: gpo_cfg_reg <= reg_wdata;
        ADDR_GPO_OUT: gpo_out_reg <= reg_wdata;
        ADDR_IRQ_MASK: irq_mask_reg <= reg_wdata;
        default:
        begin
          // Indexed registers; other addresses are ignored.
          for (int i = 0; i < NUM_GPO; i++)
          begin
            if (reg_addr == ADDR_PG_MASK_A + ADDR_W'(i))
            begin
              pg_mask_reg[i] <= reg_wdata;
            end
          end
          for (int i = 0; i < NUM_RAILS; i++)
          begin
            if (reg_addr == ADDR_VSEL_NORM + ADDR_W'(i))
            begin
              vsel_norm_reg[i] <= reg_wdata;
            end
            if (reg_addr == ADDR_VSEL_SLEEP + ADDR_W'(i))
            begin
              vsel_sleep_reg[i] <= reg_wdata;
            end
          end
        end
      endcase
    end
  end

  // Sticky status: writing one clears, a new event wins over the clear.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      irq_status_reg <= RST_ZERO;
    end
    else if (ce)
    begin
      for (int i = 0; i < DATA_W; i++)
      begin
        if (ev_set[i])
        begin
          irq_status_reg[i] <= 1'b1;
        end
        else if (wr_irq_status && reg_wdata[i])
        begin
          irq_status_reg[i] <= 1'b0;
        end
      end
    end
  end

  // Interrupt pin: pulled low while an unmasked flag is set, else released.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      interrupt_out_n_o <= 1'b0;
      interrupt_out_n_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      interrupt_out_n_o <= 1'b0;
      interrupt_out_n_oe_n <= !(|(irq_status_reg & irq_mask_reg));
    end
  end

  // Read port: data one cycle after the strobe, unmapped reads zero.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      reg_rdata <= '0;
    end
    else if (ce)
    begin
      reg_rdata <= '0;
      if (reg_re)
      begin
        case (reg_addr)
          ADDR_MAP_A: reg_rdata <= map_a_reg;
          ADDR_MAP_B: reg_rdata <= map_b_reg;
          ADDR_PIN_CFG: reg_rdata <= pin_cfg_reg;
          ADDR_SLEEP_MAP: reg_rdata <= sleep_map_reg;
          ADDR_SW_EN: reg_rdata <= sw_en_reg;
          ADDR_GPO_CFG: reg_rdata <= gpo_cfg_reg;
          ADDR_GPO_OUT: reg_rdata <= gpo_out_reg;
          ADDR_PG_STATUS: reg_rdata <= DATA_W'(rail_pg);
          ADDR_IRQ_STATUS: reg_rdata <= irq_status_reg;
          ADDR_IRQ_MASK: reg_rdata <= irq_mask_reg;
          ADDR_RAIL_STATE: reg_rdata <= DATA_W'(rail_enable);
          ADDR_SLEEP_STATE: reg_rdata <= DATA_W'(rail_sleep);
          default:
          begin
            // Indexed registers.
            for (int i = 0; i < NUM_GPO; i++)
            begin
              if (reg_addr == ADDR_PG_MASK_A + ADDR_W'(i))
              begin
                reg_rdata <= pg_mask_reg[i];
              end
            end
            for (int i = 0; i < NUM_RAILS; i++)
            begin
              if (reg_addr == ADDR_VSEL_NORM + ADDR_W'(i))
              begin
                reg_rdata <= vsel_norm_reg[i];
              end
              if (reg_addr == ADDR_VSEL_SLEEP + ADDR_W'(i))
              begin
                reg_rdata <= vsel_sleep_reg[i];
              end
            end
          end
        endcase
      end
    end
  end

  // One driver per general-purpose output.
  for (genvar g = 0; g < NUM_GPO; g++)
  begin : gen_gpo
    gpo_drive u_gpo (
      .clk(clk),
      .sys_rst(sys_rst),
      .ce(ce),
      .rail_pg(rail_pg),
      .pg_mask(pg_mask_reg[g][NUM_RAILS-1:0]),
      .sw_mode(gpo_cfg_reg[GPO_CFG_SW_LSB + g]),
      .open_drain(gpo_cfg_reg[GPO_CFG_OD_LSB + g]),
      .sw_value(gpo_out_reg[g]),
      .pin_o(gpo_pin[g]),
      .pin_oe_n(gpo_oe_n[g])
    );
  end

  assign general_out_a_o = gpo_pin[0];
  assign general_out_a_oe_n = gpo_oe_n[0];
  assign general_out_b_o = gpo_pin[1];
  assign general_out_b_oe_n = gpo_oe_n[1];
  assign general_out_c_o = gpo_pin[2];
  assign general_out_c_oe_n = gpo_oe_n[2];
endmodule : pmic_control_pin_logic
`default_nettype wire

// >>> shared/pmic_pin_pkg.sv
// Constants shared by the control-pin logic and its output drivers.
`default_nettype none
package pmic_pin_pkg;
  // Bus and rail geometry.
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;
  localparam int NUM_RAILS = 4;
  localparam int NUM_GPO = 3;
  localparam int NUM_EVENTS = 5;

  // Register offsets.
  localparam logic [4:0] ADDR_MAP_A = 5'h00;
  localparam logic [4:0] ADDR_MAP_B = 5'h01;
  localparam logic [4:0] ADDR_PIN_CFG = 5'h02;
  localparam logic [4:0] ADDR_SLEEP_MAP = 5'h03;
  localparam logic [4:0] ADDR_SW_EN = 5'h04;
  localparam logic [4:0] ADDR_GPO_CFG = 5'h05;
  localparam logic [4:0] ADDR_GPO_OUT = 5'h06;
  localparam logic [4:0] ADDR_PG_MASK_A = 5'h07;
  localparam logic [4:0] ADDR_PG_STATUS = 5'h0A;
  localparam logic [4:0] ADDR_IRQ_STATUS = 5'h0B;
  localparam logic [4:0] ADDR_IRQ_MASK = 5'h0C;
  localparam logic [4:0] ADDR_RAIL_STATE = 5'h0D;
  localparam logic [4:0] ADDR_SLEEP_STATE = 5'h0E;
  localparam logic [4:0] ADDR_VSEL_NORM = 5'h10;
  localparam logic [4:0] ADDR_VSEL_SLEEP = 5'h18;

  // Field positions.
  localparam int PIN_CFG_SLEEP_BIT = 0;
  localparam int GPO_CFG_OD_LSB = 0;
  localparam int GPO_CFG_SW_LSB = 3;
  localparam int EV_A_RISE = 0;
  localparam int EV_A_FALL = 1;
  localparam int EV_B_RISE = 2;
  localparam int EV_B_FALL = 3;
  localparam int EV_PG_FAULT = 4;

  // Reset values.
  localparam logic [7:0] RST_MAP = 8'h00;
  localparam logic [7:0] RST_PIN_CFG = 8'h00;
  localparam logic [7:0] RST_GPO_CFG = 8'h07;
  localparam logic [7:0] RST_VSEL_NORM = 8'h40;
  localparam logic [7:0] RST_VSEL_SLEEP = 8'h20;
  localparam logic [7:0] RST_ZERO = 8'h00;
endpackage : pmic_pin_pkg
`default_nettype wire

// >>> rtl/gpo_drive.sv
// One general-purpose output pin driver with selectable source and drive.
`timescale 1ns/1ps
`default_nettype none
module gpo_drive
  import pmic_pin_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic ce, // Clock enable; state holds while low.
  input wire logic [pmic_pin_pkg::NUM_RAILS-1:0] rail_pg, // Rail power-good.
  input wire logic [pmic_pin_pkg::NUM_RAILS-1:0] pg_mask, // Rails watched.
  input wire logic sw_mode, // High: follow sw_value.
  input wire logic open_drain, // High: open-drain, low: push-pull.
  input wire logic sw_value, // Register bit driven by software.
  output logic pin_o, // Pin output level.
  output logic pin_oe_n // Pin output enable, low while driving.
);
  // True only when every watched rail reports power good.
  function automatic logic all_good(input logic [NUM_RAILS-1:0] pg,
                                    input logic [NUM_RAILS-1:0] mask);
    all_good = &(pg | ~mask);
  endfunction : all_good

  logic level; // Logical level the pin should show.

  // Pick the level from power-good or from the register bit.
  always_comb
  begin
    if (sw_mode)
    begin
      level = sw_value;
    end
    else
    begin
      level = all_good(rail_pg, pg_mask);
    end
  end

  // Register the pin; open-drain releases the line for a high level.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      pin_o <= 1'b0;
      pin_oe_n <= 1'b1;
    end
    else if (ce)
    begin
      if (open_drain)
      begin
        pin_o <= 1'b0;
        pin_oe_n <= level;
      end
      else
      begin
        pin_o <= level;
        pin_oe_n <= 1'b0;
      end
    end
  end
endmodule : gpo_drive
`default_nettype wire

// >>> verif/rail_pg_model.sv
// Model of the regulators that report power-good to the pin logic.
`timescale 1ns/1ps
`default_nettype none
module rail_pg_model #(
  parameter int PG_DLY = 3 // Cycles from rail on to power good.
) (
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset, active high.
  input wire logic [3:0] rail_enable, // Rails switched on.
  input wire logic [3:0] pg_kill, // Faults forced by the bench.
  output logic [3:0] rail_pg // Power-good per rail.
);
  logic [3:0] ramp_reg [PG_DLY]; // Soft-start delay line.

  // A rail ramps for a while before it reports good.
  always_ff @(posedge clk)
  begin
    ramp_reg[0] <= sys_rst ? 4'h0 : rail_enable;
    for (int i = 1; i < PG_DLY; i++)
    begin
      ramp_reg[i] <= sys_rst ? 4'h0 : ramp_reg[i-1];
    end
  end

  // Good is lost at once when a rail is cut or faulted.
  assign rail_pg = ramp_reg[PG_DLY-1] & rail_enable & ~pg_kill;
endmodule : rail_pg_model
`default_nettype wire

// >>> verif/pmic_pin_chk.sv
// Port checker for the control-pin logic.
`timescale 1ns/1ps
`default_nettype none
module pmic_pin_chk
  import pmic_pin_pkg::*;
(
  input wire logic clk, // System clock.
  input wire logic sys_rst, // Synchronous reset.
  input wire logic reg_we, // Write strobe.
  input wire logic rail_group_enable_in_a, // Group enable pin.
  input wire logic rail_enable_or_sleep_in, // Enable or sleep pin.
  input wire logic [pmic_pin_pkg::NUM_RAILS-1:0] rail_pg, // Power-good.
  input wire logic [pmic_pin_pkg::NUM_RAILS-1:0] rail_enable, // Rail on.
  input wire logic [pmic_pin_pkg::NUM_RAILS-1:0] rail_sleep, // Sleep.
  input wire logic interrupt_out_n_o, // Interrupt level.
  input wire logic interrupt_out_n_oe_n, // Interrupt enable.
  input wire logic general_out_a_o, // GPO a level.
  input wire logic general_out_a_oe_n, // GPO a enable.
  input wire logic general_out_b_o, // GPO b level.
  input wire logic general_out_b_oe_n, // GPO b enable.
  input wire logic general_out_c_o, // GPO c level.
  input wire logic general_out_c_oe_n // GPO c enable.
);
  logic [2:0] we_hist_reg; // Write strobes of the last three cycles.
  logic wr_seen; // A write may explain an output change.

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Register writes reach the outputs within three cycles.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      we_hist_reg <= 3'h0;
    end
    else
    begin
      we_hist_reg <= {we_hist_reg[1:0], reg_we};
    end
  end
  assign wr_seen = |we_hist_reg;

  sequence s_rail_up;
    (rail_enable & ~$past(rail_enable)) != 4'h0;
  endsequence
  sequence s_rail_down;
    (~rail_enable & $past(rail_enable)) != 4'h0;
  endsequence

  property p_rail_up;
    s_rail_up |-> $past(rail_group_enable_in_a)
      || $past(rail_enable_or_sleep_in) || wr_seen;
  endproperty
  a_rail_up: assert property (p_rail_up)
    else $error("rail switched on without a cause");

  property p_rail_down;
    s_rail_down |-> !$past(rail_group_enable_in_a)
      || !$past(rail_enable_or_sleep_in) || wr_seen;
  endproperty
  a_rail_down: assert property (p_rail_down)
    else $error("rail switched off without a cause");

  property p_sleep_enter;
    (rail_sleep & ~$past(rail_sleep)) != 4'h0
      |-> !$past(rail_enable_or_sleep_in) || wr_seen;
  endproperty
  a_sleep_enter: assert property (p_sleep_enter)
    else $error("sleep entered with sleep pin high");

  property p_sleep_leave;
    (~rail_sleep & $past(rail_sleep)) != 4'h0
      |-> $past(rail_enable_or_sleep_in) || wr_seen;
  endproperty
  a_sleep_leave: assert property (p_sleep_leave)
    else $error("sleep left with sleep pin low");

  property p_irq_low;
    interrupt_out_n_o == 1'b0;
  endproperty
  a_irq_low: assert property (p_irq_low)
    else $error("interrupt line driven high");

  property p_irq_release;
    $rose(interrupt_out_n_oe_n) |-> wr_seen;
  endproperty
  a_irq_release: assert property (p_irq_release)
    else $error("interrupt released without a write");

  property p_drive_kind;
    !(general_out_a_o && general_out_a_oe_n)
      && !(general_out_b_o && general_out_b_oe_n)
      && !(general_out_c_o && general_out_c_oe_n);
  endproperty
  a_drive_kind: assert property (p_drive_kind)
    else $error("output level high while pin released");

  property p_gpo_cause;
    $changed({general_out_a_o, general_out_a_oe_n})
      |-> $past(rail_pg) != $past(rail_pg, 2) || wr_seen;
  endproperty
  a_gpo_cause: assert property (p_gpo_cause)
    else $error("output a changed without a cause");
endmodule : pmic_pin_chk

bind pmic_control_pin_logic pmic_pin_chk u_chk (.clk, .sys_rst,
  .reg_we, .rail_group_enable_in_a, .rail_enable_or_sleep_in, .rail_pg,
  .rail_enable, .rail_sleep, .interrupt_out_n_o, .interrupt_out_n_oe_n,
  .general_out_a_o, .general_out_a_oe_n, .general_out_b_o,
  .general_out_b_oe_n, .general_out_c_o, .general_out_c_oe_n);
`default_nettype wire

// >>> verif/tb_top.sv
// Self-checking bench for the control-pin logic.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import pmic_pin_pkg::*;
  typedef struct {logic a; logic b; logic [3:0] en;} row_s;
  logic clk = 1'b0; // System clock.
  logic sys_rst = 1'b1; // Reset, active high.
  logic [4:0] reg_addr = 5'h00; // Register address.
  logic [7:0] reg_wdata = 8'h00; // Write data.
  logic reg_we = 1'b0; // Write strobe.
  logic reg_re = 1'b0; // Read strobe.
  logic ce = 1'b1; // Clock enable.
  logic pin_a = 1'b0; // Group enable pin.
  logic pin_b = 1'b1; // Enable or sleep pin.
  logic [3:0] pg_kill = 4'h0; // Faults forced on rails.
  logic [7:0] rdata; // Last read data.
  logic [7:0] rdat; // Design read data.
  logic [3:0] rail_pg, rail_enable, rail_sleep; // Rail signals.
  logic [31:0] rail_vsel; // Voltage codes.
  logic irq_o, irq_oe_n, ga_o, ga_oe_n, gb_o, gb_oe_n, gc_o, gc_oe_n;
  int num_errors = 0; // Mismatches.
  int total_checks = 0; // Comparisons.
  row_s rows[5] = '{'{1'b0, 1'b0, 4'h0}, '{1'b1, 1'b0, 4'h3},
    '{1'b0, 1'b1, 4'hC}, '{1'b1, 1'b1, 4'hF}, '{1'b0, 1'b0, 4'h0}};
  logic [7:0] outs[2] = '{8'h05, 8'h02}; // Software output values.

  always #5 clk = ~clk;

  rail_pg_model #(.PG_DLY(3)) u_pg (.clk(clk), .sys_rst(sys_rst),
    .rail_enable(rail_enable), .pg_kill(pg_kill), .rail_pg(rail_pg));

  pmic_control_pin_logic uut (.clk(clk), .sys_rst(sys_rst), .ce(ce),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(rdat), .rail_group_enable_in_a(pin_a),
    .rail_enable_or_sleep_in(pin_b), .rail_pg(rail_pg),
    .rail_enable(rail_enable), .rail_sleep(rail_sleep),
    .rail_vsel(rail_vsel), .interrupt_out_n_o(irq_o),
    .interrupt_out_n_oe_n(irq_oe_n), .general_out_a_o(ga_o),
    .general_out_a_oe_n(ga_oe_n), .general_out_b_o(gb_o),
    .general_out_b_oe_n(gb_oe_n), .general_out_c_o(gc_o),
    .general_out_c_oe_n(gc_oe_n));

  // Prints the counts and the verdict, then stops.
  task automatic summarize();
    $display("Checks %0d, errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : summarize

  // Compares a result against its expected value.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED at %0t: got %h, want %h", $time, got, exp);
    end
  endtask : chk

  // Waits n edges, then settles to the falling edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : cyc

  // One-cycle register write.
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_we <= 1'b0;
  endtask : wr

  // One-cycle register read; data is taken in the following cycle.
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    reg_re <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_re <= 1'b0;
    @(negedge clk);
    rdata = rdat;
  endtask : rd

  // Sets both control pins and lets the rails follow.
  task automatic pins(input logic a, input logic b);
    @(posedge clk);
    pin_a <= a;
    pin_b <= b;
    cyc(3);
  endtask : pins

  // Bounded wait for the interrupt enable to reach a level.
  task automatic wait_irq(input logic exp);
    @(negedge clk);
    for (int i = 0; i < 10 && irq_oe_n !== exp; i++)
      @(negedge clk);
    chk(irq_oe_n, exp);
    if (irq_oe_n !== exp)
      summarize();
  endtask : wait_irq

  // Cuts a hung run short.
  initial
  begin
    #200000;
    chk(1'b0, 1'b1);
    summarize();
  end

  // Main sequence: reset, table rows, then the awkward cases.
  initial
  begin
    rdata = 8'h00;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(0);
    chk({ga_o, ga_oe_n, gb_o, gb_oe_n, gc_o, gc_oe_n, irq_o, irq_oe_n,
      rail_enable}, 12'h550);
    rd(ADDR_GPO_CFG);
    chk(rdata, RST_GPO_CFG);
    rd(ADDR_VSEL_SLEEP);
    chk(rdata, RST_VSEL_SLEEP);
    rd(5'h1F);
    chk(rdata, 8'h00);
    wr(ADDR_MAP_A, 8'h03);
    wr(ADDR_MAP_B, 8'h0C);
    foreach (rows[i])
    begin
      pins(rows[i].a, rows[i].b);
      chk(rail_enable, rows[i].en);
    end
    // Sleep mode on the combined pin, rail 0 in its group.
    wr(ADDR_PIN_CFG, 8'h01);
    wr(ADDR_SLEEP_MAP, 8'h01);
    wr(ADDR_VSEL_SLEEP, 8'h15);
    pins(1'b1, 1'b1);
    chk({rail_sleep, rail_enable, rail_vsel[15:0]}, 24'h034040);
    pins(1'b1, 1'b0);
    chk({rail_sleep, rail_enable, rail_vsel[15:0]}, 24'h134015);
    pins(1'b1, 1'b1);
    chk({rail_sleep, rail_vsel[15:0]}, 20'h04040);
    // Interrupt raised, masked, unmasked and cleared.
    wr(ADDR_IRQ_MASK, 8'h02);
    wr(ADDR_IRQ_STATUS, 8'h1F);
    wait_irq(1'b1);
    pins(1'b0, 1'b1);
    wait_irq(1'b0);
    rd(ADDR_IRQ_STATUS);
    chk(rdata[EV_A_FALL], 1'b1);
    wr(ADDR_IRQ_MASK, 8'h00);
    wait_irq(1'b1);
    wr(ADDR_IRQ_MASK, 8'h02);
    wait_irq(1'b0);
    wr(ADDR_IRQ_STATUS, 8'h02);
    wait_irq(1'b1);
    rd(ADDR_IRQ_STATUS);
    chk(rdata[EV_A_FALL], 1'b0);
    // An event and its clear in one cycle: the event wins.
    @(posedge clk);
    reg_we <= 1'b1;
    reg_addr <= ADDR_IRQ_STATUS;
    reg_wdata <= 8'h01;
    pin_a <= 1'b1;
    @(posedge clk);
    reg_we <= 1'b0;
    rd(ADDR_IRQ_STATUS);
    chk(rdata[EV_A_RISE], 1'b1);
    // Power-good output of rails 0 and 1 on output a.
    wr(ADDR_PG_MASK_A, 8'h03);
    pins(1'b1, 1'b1);
    cyc(4);
    chk({ga_o, ga_oe_n}, 2'b01);
    @(posedge clk);
    pg_kill <= 4'h2;
    cyc(3);
    chk({ga_o, ga_oe_n}, 2'b00);
    wr(ADDR_GPO_CFG, 8'h06);
    cyc(2);
    chk({ga_o, ga_oe_n}, 2'b00);
    @(posedge clk);
    pg_kill <= 4'h0;
    cyc(3);
    chk({ga_o, ga_oe_n}, 2'b10);
    // All outputs follow software bits, push-pull then open-drain.
    wr(ADDR_GPO_CFG, 8'h38);
    foreach (outs[i])
    begin
      wr(ADDR_GPO_OUT, outs[i]);
      cyc(2);
      chk({ga_o, gb_o, gc_o, ga_oe_n, gb_oe_n, gc_oe_n},
        {outs[i][0], outs[i][1], outs[i][2], 3'b000});
    end
    wr(ADDR_GPO_CFG, 8'h3F);
    cyc(2);
    chk({ga_o, gb_o, gc_o, ga_oe_n, gb_oe_n, gc_oe_n},
      6'b000010);
    // Clock enable low freezes the rails; they follow once it returns.
    @(posedge clk);
    ce <= 1'b0;
    pin_a <= 1'b0;
    cyc(3);
    chk(rail_enable, 4'h3);
    @(posedge clk);
    ce <= 1'b1;
    cyc(2);
    chk(rail_enable, 4'h0);
    // A rail forced on by software shows in the rail state register.
    wr(ADDR_SW_EN, 8'h04);
    rd(ADDR_RAIL_STATE);
    chk(rdata, 8'h04);
    // A second reset in mid-run restores outputs and registers.
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    cyc(0);
    chk({ga_o, ga_oe_n, gb_o, gb_oe_n, gc_o, gc_oe_n, irq_o, irq_oe_n,
      rail_enable}, 12'h550);
    chk(rail_vsel, 32'h0);
    rd(ADDR_GPO_CFG);
    chk(rdata, RST_GPO_CFG);
    rd(ADDR_IRQ_STATUS);
    chk(rdata, 8'h00);
    summarize();
  end
endmodule : tb_top
`default_nettype wire
